// ### dv/tape_recorder_model.sv
// Purpose: recorder-side sink that captures recorded cells
// Assumes: cell value is settled when bit clock first reads high
// Notes:   newest cell in bit 0
`timescale 1ns/10ps
module tape_recorder_model (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // recorded stream
  input  wire logic        bit_clk_in,
  input  wire logic        nrz_in,
  // captured cells
  output logic [63:0]      hist_out
);
  logic bclk_prev_r;

  always_ff @(posedge clk_in) begin
    bclk_prev_r <= bit_clk_in;
    if (rst_in) begin
      hist_out <= 64'h0;
    end else if (bit_clk_in && !bclk_prev_r) begin
      hist_out <= {hist_out[62:0], nrz_in};
    end
  end
endmodule : tape_recorder_model

// ### dv/tb_top.sv
// Purpose: self-checking bench for the format unit
// Assumes: shortened frame of 20000 cycles, check period 600, first 500
// Notes:   phase offset 5000 held from reset
`timescale 1ns/10ps
module tb_top;
  localparam int FRAME = 20000;
  localparam int DGAP_AT = FRAME - tfg_pkg::SYNC_TAIL_CYC - tfg_pkg::DGAP_CYC;
  logic                        clk_in, rst_in, test_mode_in, sample_in;
  logic                        sample_valid_in, tc_nrz_in, sample_ready_out, tc_take_out;
  logic                        nrz_out, bit_clk_out, diphase_out, tc_diphase_out;
  logic [tfg_pkg::PHASE_W-1:0] phase_in;
  tfg_pkg::timing_out_t        tim;
  tfg_pkg::frame_strobes_t     stb;
  logic [63:0]                 hist;
  int                          bad_count, total_checks;

  tfg_top #(.FRAME_CYC(FRAME), .CHK_PER_CYC(600), .CHK_FIRST_CYC(500)) i_dut (
    .CLK_IN(clk_in), .RST_IN(rst_in), .PHASE_IN(phase_in), .TEST_MODE_IN(test_mode_in),
    .SAMPLE_IN(sample_in), .SAMPLE_VALID_IN(sample_valid_in),
    .SAMPLE_READY_OUT(sample_ready_out), .TC_NRZ_IN(tc_nrz_in), .TC_TAKE_OUT(tc_take_out),
    .TIMING_OUT(tim), .STROBES_OUT(stb), .NRZ_OUT(nrz_out), .BIT_CLK_OUT(bit_clk_out),
    .DIPHASE_OUT(diphase_out), .TC_DIPHASE_OUT(tc_diphase_out));
  tape_recorder_model i_rec (.clk_in(clk_in), .rst_in(rst_in), .bit_clk_in(bit_clk_out),
    .nrz_in(nrz_out), .hist_out(hist));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task conclude;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task check(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %0d seen %0d", what, e, g);
    end
  endtask : check

  task step;
    @(posedge clk_in);
    #10;
    if (tc_take_out) tc_nrz_in = ~tc_nrz_in;
  endtask : step

  // wait for a falling edge of one strobe bit
  task wait_fall(input int sel);
    while (stb[sel] !== 1'b1) step;
    while (stb[sel] !== 1'b0) step;
  endtask : wait_fall

  function bit found(logic [63:0] h, logic [31:0] p, int w);
    for (int k = 0; k < 20; k++)
      if (((h >> k) & ((64'h1 << w) - 64'h1)) === 64'(p)) return 1'b1;
    return 1'b0;
  endfunction : found

  task measure(input int idx);
    int t60, t1, ci, gp, sy, fc, ck, wd, fs, rh, au, tc, rr;
    logic pa, pr;
    {t60, t1, ci, gp, sy, fc, ck, wd, fs, rh, au, tc} = '0;
    rr = -1;
    pr = 1'b1;
    pa = tim.aud_clk;
    for (int i = 0; i < FRAME; i++) begin
      t60 += tim.tick60;
      t1 += !tim.tick1_n;
      ci += stb.clk_interrogate;
      gp += stb.write_gap;
      sy += stb.sync_ins;
      fc += stb.fcnt_ins;
      ck += stb.chk_ins;
      wd += !stb.write_data;
      fs += tim.fcnt_sync;
      rh += tim.ref60;
      au += tim.aud_clk && !pa;
      tc += tc_take_out;
      if (tim.ref60 && !pr && rr < 0) rr = i;
      pa = tim.aud_clk;
      pr = tim.ref60;
      step;
    end
    check("tick60", tfg_pkg::TICK_CYC, t60);
    check("tick1", idx == 0 ? tfg_pkg::TICK_CYC : 0, t1);
    check("ref60 high", FRAME / 2, rh);
    check("ref60 rise", FRAME - 5000, rr);
    check("aud clk", 64, au);
    check("interrogate", tfg_pkg::CI_CYC, ci);
    check("write gap", tfg_pkg::GAP_CYC, gp);
    check("sync", tfg_pkg::SYNC_HEAD_CYC + tfg_pkg::SYNC_TAIL_CYC, sy);
    check("frame count", tfg_pkg::FCNT_CYC, fc);
    check("write data low", tfg_pkg::DGAP_CYC, wd);
    check("check bits", ((DGAP_AT - 501) / 600 + 1) * tfg_pkg::CHK_CYC, ck);
    check("frame sync", idx == 0 ? tfg_pkg::FCS_CYC : 0, fs);
    check("tc takes", 64, tc);
  endtask : measure

  task check_slot;
    wait_fall(1);
    repeat (6) step;
    check("check pattern", 1, found(hist, 32'h0FE, 10));
  endtask : check_slot

  task test_pattern;
    test_mode_in = 1'b1;
    wait_fall(1);
    repeat (170) step;
    check("pattern repeat", hist[59:30], hist[29:0]);
    check("pattern live", 1, |hist[29:0]);
    test_mode_in = 1'b0;
  endtask : test_pattern

  task fifo_fill_drain;
    logic [7:0] pat;
    pat = 8'hB4;
    wait_fall(0);
    repeat (3) step;
    for (int i = 0; i < 8; i++) begin
      sample_in = pat[7 - i];
      sample_valid_in = 1'b1;
      check("ready", 1, sample_ready_out);
      step;
    end
    check("ready full", 0, sample_ready_out);
    step;
    check("ready held", 0, sample_ready_out);
    sample_valid_in = 1'b0;
    wait_fall(2);
    check("head sync", 1, found(hist, 32'hF8E, 12));
    repeat (40) step;
    check("data order", 1, found(hist, 32'hB40, 12));
  endtask : fifo_fill_drain

  // mid-run reset restarts frame and second counts together
  task reset_restart;
    rst_in = 1'b1;
    repeat (2) step;
    check("ready in reset", 1, sample_ready_out);
    rst_in = 1'b0;
    step;
    check("tick after reset", 1, tim.tick60);
    check("second after reset", 0, tim.tick1_n);
    check("frame sync after reset", 1, tim.fcnt_sync);
    check("interrogate after reset", 1, stb.clk_interrogate);
  endtask : reset_restart

  initial begin
    repeat (90000) @(posedge clk_in);
    bad_count++;
    conclude;
  end

  initial begin
    {rst_in, phase_in} = {1'b1, 18'h01388};
    {test_mode_in, sample_in, sample_valid_in, tc_nrz_in} = 4'h0;
    {bad_count, total_checks} = '0;
    repeat (6) @(posedge clk_in);
    #10;
    rst_in = 1'b0;
    while (tim.tick60 !== 1'b1) step;
    measure(0);
    measure(1);
    check_slot;
    test_pattern;
    fifo_fill_drain;
    reset_restart;
    conclude;
  end
endmodule : tb_top

bind tfg_top tfg_checker i_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .TC_TAKE_OUT(TC_TAKE_OUT),
  .TIMING_OUT(TIMING_OUT), .STROBES_OUT(STROBES_OUT), .NRZ_OUT(NRZ_OUT),
  .BIT_CLK_OUT(BIT_CLK_OUT), .DIPHASE_OUT(DIPHASE_OUT), .TC_DIPHASE_OUT(TC_DIPHASE_OUT));

// ### dv/tfg_properties.sv
// Purpose: concurrent checks on the format unit ports
// Assumes: one clock domain, synchronous active-high reset
// Notes:   run counters measure strobe widths at their trailing edge
`timescale 1ns/10ps
module tfg_checker (
  // clock and reset
  input  wire logic                    CLK_IN,
  input  wire logic                    RST_IN,
  // observed outputs
  input  wire logic                    TC_TAKE_OUT,
  input  wire tfg_pkg::timing_out_t    TIMING_OUT,
  input  wire tfg_pkg::frame_strobes_t STROBES_OUT,
  input  wire logic                    NRZ_OUT,
  input  wire logic                    BIT_CLK_OUT,
  input  wire logic                    DIPHASE_OUT,
  input  wire logic                    TC_DIPHASE_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  logic [15:0] ci_run_r;
  logic [15:0] gap_run_r;
  logic [15:0] wd_run_r;
  logic [3:0]  dp_quiet_r;
  logic        dp_prev_r;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ci_run_r   <= 16'h0000;
      gap_run_r  <= 16'h0000;
      wd_run_r   <= 16'h0000;
      dp_quiet_r <= 4'h0;
      dp_prev_r  <= 1'b0;
    end else begin
      ci_run_r   <= STROBES_OUT.clk_interrogate ? ci_run_r + 16'h0001 : 16'h0000;
      gap_run_r  <= STROBES_OUT.write_gap ? gap_run_r + 16'h0001 : 16'h0000;
      wd_run_r   <= STROBES_OUT.write_data ? 16'h0000 : wd_run_r + 16'h0001;
      dp_prev_r  <= DIPHASE_OUT;
      dp_quiet_r <= (DIPHASE_OUT != dp_prev_r) ? 4'h0 : dp_quiet_r + 4'h1;
    end
  end

  property p_tick_width;
    $rose(TIMING_OUT.tick60) |-> TIMING_OUT.tick60 [*3] ##1 !TIMING_OUT.tick60;
  endproperty
  a_tick_width: assert property (p_tick_width) else $error("tick60 width");
  property p_sec_align;
    !TIMING_OUT.tick1_n |-> TIMING_OUT.tick60;
  endproperty
  a_sec_align: assert property (p_sec_align) else $error("tick1 misaligned");
  property p_ci_len;
    $fell(STROBES_OUT.clk_interrogate) |-> ci_run_r == 16'(tfg_pkg::CI_CYC);
  endproperty
  a_ci_len: assert property (p_ci_len) else $error("interrogate width");
  property p_gap_len;
    $fell(STROBES_OUT.write_gap) |-> gap_run_r == 16'(tfg_pkg::GAP_CYC);
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("write gap width");
  property p_frame_head;
    $rose(TIMING_OUT.tick60) |-> STROBES_OUT.sync_ins && STROBES_OUT.clk_interrogate;
  endproperty
  a_frame_head: assert property (p_frame_head) else $error("frame head strobes");
  property p_wd_len;
    $rose(STROBES_OUT.write_data) |-> wd_run_r == 16'(tfg_pkg::DGAP_CYC);
  endproperty
  a_wd_len: assert property (p_wd_len) else $error("write data low width");
  property p_chk_width;
    $rose(STROBES_OUT.chk_ins) |-> STROBES_OUT.chk_ins [*8] ##12 STROBES_OUT.chk_ins
      ##1 !STROBES_OUT.chk_ins;
  endproperty
  a_chk_width: assert property (p_chk_width) else $error("check strobe width");
  property p_fsync_start;
    $rose(TIMING_OUT.fcnt_sync) |-> $rose(TIMING_OUT.tick60);
  endproperty
  a_fsync_start: assert property (p_fsync_start) else $error("frame sync start");
  property p_tc_toggle;
    TC_TAKE_OUT |=> TC_DIPHASE_OUT != $past(TC_DIPHASE_OUT);
  endproperty
  a_tc_toggle: assert property (p_tc_toggle) else $error("time code cell edge");
  property p_gap_ones;
    (wd_run_r > 16'h0005) && !STROBES_OUT.write_data |-> NRZ_OUT;
  endproperty
  a_gap_ones: assert property (p_gap_ones) else $error("gap not ones");
  property p_cell_toggle;
    $rose(BIT_CLK_OUT) |-> $changed(DIPHASE_OUT);
  endproperty
  a_cell_toggle: assert property (p_cell_toggle) else $error("no cell edge");
  property p_dp_busy;
    dp_quiet_r < 4'h5;
  endproperty
  a_dp_busy: assert property (p_dp_busy) else $error("diphase idle");

  c_gap: cover property ($fell(STROBES_OUT.write_data));
  c_fsync: cover property ($rose(TIMING_OUT.fcnt_sync));
  c_chk: cover property ($fell(STROBES_OUT.chk_ins));
endmodule : tfg_checker

// ### hw/tfg_pkg.sv
// Purpose: shared constants and types for the tape format timing generator
// Assumes: 10 MHz system clock, 4 Mbit/s recorded stream
// Notes:   times are in ns; cycle counts are derived from them
package tfg_pkg;

  localparam int CLK_PERIOD_NS = 100;

  // time figures
  localparam int FRAME_NS     = 16_666_667;
  localparam int TICK_NS      = 250;
  localparam int CI_NS        = 250_000;
  localparam int GAP_NS       = 156_000;
  localparam int SYNC_HEAD_NS = 3_000;
  localparam int SYNC_TAIL_NS = 6_000;
  localparam int FCNT_NS      = 2_500;
  localparam int DGAP_NS      = 167_000;
  localparam int CHK_NS       = 2_000;
  localparam int CHK_PER_NS   = 512_000;
  localparam int CHK_FIRST_NS = 510_000;
  localparam int FCS_NS       = 250_000;

  // derived cycle counts; least widths round up
  localparam int FRAME_CYC     = FRAME_NS / CLK_PERIOD_NS;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CI_CYC        = CI_NS / CLK_PERIOD_NS;
  localparam int GAP_CYC       = GAP_NS / CLK_PERIOD_NS;
  localparam int SYNC_HEAD_CYC = SYNC_HEAD_NS / CLK_PERIOD_NS;
  localparam int SYNC_TAIL_CYC = SYNC_TAIL_NS / CLK_PERIOD_NS;
  localparam int FCNT_CYC      = FCNT_NS / CLK_PERIOD_NS;
  localparam int DGAP_CYC      = DGAP_NS / CLK_PERIOD_NS;
  localparam int CHK_CYC       = CHK_NS / CLK_PERIOD_NS;
  localparam int CHK_PER_CYC   = CHK_PER_NS / CLK_PERIOD_NS;
  localparam int CHK_FIRST_CYC = CHK_FIRST_NS / CLK_PERIOD_NS;
  localparam int FCS_CYC       = FCS_NS / CLK_PERIOD_NS;

  // frames per second and audio half-bit events per frame
  localparam int FRAMES_PER_SEC = 60;
  localparam int AUD_EDGES      = 128;

  // bit clock: 4 of 5 cycles give a half-bit event (8 MHz mean)
  localparam logic [2:0] HALF_ADD = 3'h4;
  localparam logic [2:0] HALF_MOD = 3'h5;

  // field layout and insertion words
  localparam int          FLD_W       = 24;
  localparam int          FNUM_W      = 10;
  localparam int          CHK_W       = 8;
  localparam int          TP_LEN      = 30;
  localparam logic [23:0] SYNC_WORD   = 24'hF8E4C2;
  localparam logic [7:0]  CHK_PAT     = 8'h7F;
  localparam logic [29:0] TEST_PAT    = 30'h2D3C_96A5;

  localparam int CNT_W   = 18;
  localparam int PHASE_W = 18;

  typedef struct packed {
    logic clk_interrogate;
    logic write_gap;
    logic sync_ins;
    logic fcnt_ins;
    logic chk_ins;
    logic write_data;
  } frame_strobes_t;

  typedef struct packed {
    logic tick60;
    logic tick1_n;
    logic fcnt_sync;
    logic ref60;
    logic aud_clk;
  } timing_out_t;

endpackage : tfg_pkg

// ### hw/tfg_top.sv
// Purpose: format unit: frame timing, bit-stream insertion and diphase coding
// Assumes: one 10 MHz clock; sample and time-code sources run on it
// Notes:   8 MHz half-bit edges are a 4-of-5 cycle approximation
//
// Functional notes
// - 60 Hz positive tick, 0.3 us (3 cycles) wide, from the master clock.
// - 1 Hz negative tick, 0.3 us (3 cycles) wide, aligned with the 60 Hz tick.
// - 60 Hz square reference to recorder, half duty, phase set by operator.
// - audio-track clock, exactly 64 cycles per frame, locked to the frame.
// - clock-interrogate strobe high 250 us once every frame.
// - write-gap window high 156 us once every frame.
// - sync-word strobe high 3 us at frame start, 6 us at frame end.
// - frame-count strobe high 2.5 us once every frame.
// - write-data enable low 167 us every frame; no samples then.
// - frame-count sync pulse high 250 us once per second.
// - NRZ out is samples with sync word, frame count, gap, check bits inserted.
// - time code diphase-encoded onto audio track, clocked by audio clock.
// - during the data gap the stream is continuous diphase ones.
// - test mode records a fixed pattern repeating every 7.5 us.
// - each check slot carries one 8-bit minor check pattern.
// - recorder diphase shows a transition at every cell start, 250 ns cells (4 Mbit/s).
`timescale 1ns/10ps

module tfg_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  output logic [WIDTH-1:0]      rd_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  wire              push = wr_valid && wr_ready;
  wire              pop  = rd_valid && rd_ready;

  assign wr_ready = (cnt_r != (AW+1)'(DEPTH));
  assign rd_valid = (cnt_r != '0);
  assign rd_data  = mem_r[rp_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tfg_fifo

module tfg_top #(
  parameter int FRAME_CYC     = tfg_pkg::FRAME_CYC,
  parameter int CHK_PER_CYC   = tfg_pkg::CHK_PER_CYC,
  parameter int CHK_FIRST_CYC = tfg_pkg::CHK_FIRST_CYC,
  parameter int FIFO_DEPTH    = 8
) (
  // clock and reset
  input  wire logic                          CLK_IN,
  input  wire logic                          RST_IN,
  // operator controls (asynchronous)
  input  wire logic [tfg_pkg::PHASE_W-1:0]   PHASE_IN,
  input  wire logic                          TEST_MODE_IN,
  // sample stream
  input  wire logic                          SAMPLE_IN,
  input  wire logic                          SAMPLE_VALID_IN,
  output logic                               SAMPLE_READY_OUT,
  // time code stream
  input  wire logic                          TC_NRZ_IN,
  output logic                               TC_TAKE_OUT,
  // timing and strobes
  output tfg_pkg::timing_out_t               TIMING_OUT,
  output tfg_pkg::frame_strobes_t            STROBES_OUT,
  // recorded streams
  output logic                               NRZ_OUT,
  output logic                               BIT_CLK_OUT,
  output logic                               DIPHASE_OUT,
  output logic                               TC_DIPHASE_OUT
);
  localparam int CW = tfg_pkg::CNT_W;

  // test mode through two flops, phase through three; phase word taken once it holds still
  localparam int PW = tfg_pkg::PHASE_W;
  logic [PW-1:0] phase_s1_r, phase_s2_r, phase_s3_r, phase_r;
  logic          test_s1_r, test_r;
  wire  [PW-1:0] phase_lim = (phase_s3_r >= PW'(FRAME_CYC)) ? PW'(FRAME_CYC - 1) : phase_s3_r;
  always_ff @(posedge CLK_IN) begin
    phase_s1_r <= PHASE_IN;
    phase_s2_r <= phase_s1_r;
    phase_s3_r <= phase_s2_r;
    test_s1_r  <= TEST_MODE_IN;
    test_r     <= test_s1_r;
  end
  // bits of a moving word may land in different cycles
  always_ff @(posedge CLK_IN) begin
    if (phase_s3_r == phase_s2_r) begin
      phase_r <= phase_lim;
    end
  end

  // frame and second counters
  logic [CW-1:0] fcnt_r;
  logic [5:0]    sec_r;
  logic [tfg_pkg::FNUM_W-1:0] fnum_r;
  wire  frame_end = (fcnt_r == CW'(FRAME_CYC - 1));
  wire  frame_go  = (fcnt_r == '0);
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      fcnt_r <= '0;
      sec_r  <= '0;
      fnum_r <= '0;
    end else if (frame_end) begin
      fcnt_r <= '0;
      fnum_r <= fnum_r + 1'b1;
      sec_r  <= (sec_r == 6'(tfg_pkg::FRAMES_PER_SEC - 1)) ? '0 : sec_r + 1'b1;
    end else begin
      fcnt_r <= fcnt_r + 1'b1;
    end
  end

  function automatic logic in_win(input logic [CW-1:0] c, input int lo, input int len);
    in_win = (c >= CW'(lo)) && (c < CW'(lo + len));
  endfunction : in_win

  // frame windows; data gap sits just before the tail sync word
  // tail and the next head sync run together on the strobe
  localparam int TAIL_AT = FRAME_CYC - tfg_pkg::SYNC_TAIL_CYC;
  localparam int DGAP_AT = TAIL_AT - tfg_pkg::DGAP_CYC;
  wire tick60_w = in_win(fcnt_r, 0, tfg_pkg::TICK_CYC);
  wire tick1_w  = tick60_w && (sec_r == '0);
  wire ci_w     = in_win(fcnt_r, 0, tfg_pkg::CI_CYC);
  wire wgap_w   = in_win(fcnt_r, DGAP_AT, tfg_pkg::GAP_CYC);
  wire head_w   = in_win(fcnt_r, 0, tfg_pkg::SYNC_HEAD_CYC);
  wire tail_w   = in_win(fcnt_r, TAIL_AT, tfg_pkg::SYNC_TAIL_CYC);
  wire sync_w   = head_w || tail_w;
  wire fcs_w    = in_win(fcnt_r, 0, tfg_pkg::FCS_CYC) && (sec_r == '0);
  wire fc_w     = in_win(fcnt_r, tfg_pkg::SYNC_HEAD_CYC, tfg_pkg::FCNT_CYC);
  wire dgap_w   = in_win(fcnt_r, DGAP_AT, tfg_pkg::DGAP_CYC);

  // check-bit slots every period until the data gap
  logic [CW-1:0] chk_at_r;
  logic [5:0]    chk_left_r;
  wire chk_go = (fcnt_r == chk_at_r) && (fcnt_r < CW'(DGAP_AT));
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || frame_end) begin
      chk_at_r   <= CW'(CHK_FIRST_CYC);
      chk_left_r <= '0;
    end else if (chk_go) begin
      chk_at_r   <= chk_at_r + CW'(CHK_PER_CYC);
      chk_left_r <= 6'(tfg_pkg::CHK_CYC);
    end else if (chk_left_r != '0) begin
      chk_left_r <= chk_left_r - 1'b1;
    end
  end
  wire chk_w = chk_go || (chk_left_r > 6'h1);

  // reference square wave with operator phase offset
  wire [CW:0]   ph_sum = {1'b0, fcnt_r} + (CW+1)'(phase_r);
  wire [CW:0]   ph_wr  = (ph_sum >= (CW+1)'(FRAME_CYC)) ? ph_sum - (CW+1)'(FRAME_CYC) : ph_sum;
  wire          ref_w  = (ph_wr < (CW+1)'(FRAME_CYC / 2));

  // audio clock: 128 edges per frame by fractional accumulation
  logic [CW:0] aacc_r;
  logic        aud_r;
  logic        aud_ph_r;
  wire  [CW:0] aacc_sum = aacc_r + (CW+1)'(tfg_pkg::AUD_EDGES);
  wire         aud_ev   = (aacc_sum >= (CW+1)'(FRAME_CYC));
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || frame_end) begin
      aacc_r <= '0;
      aud_r  <= 1'b0;
      aud_ph_r <= 1'b0;
    end else if (aud_ev) begin
      aacc_r   <= aacc_sum - (CW+1)'(FRAME_CYC);
      aud_r    <= ~aud_r;
      aud_ph_r <= ~aud_ph_r;
    end else begin
      aacc_r <= aacc_sum;
    end
  end

  // time code diphase: edge at each cell start, mid-cell edge for a one
  logic tc_bit_r;
  logic tc_dp_r;
  wire  tc_cell = aud_ev && !aud_ph_r;
  wire  tc_mid  = aud_ev && aud_ph_r;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      tc_bit_r <= 1'b0;
      tc_dp_r  <= 1'b0;
    end else if (tc_cell) begin
      tc_bit_r <= TC_NRZ_IN;
      tc_dp_r  <= ~tc_dp_r;
    end else if (tc_mid && tc_bit_r) begin
      tc_dp_r  <= ~tc_dp_r;
    end
  end

  // half-bit events, 4 of 5 cycles, for the 4 Mbit/s stream
  logic [2:0] hacc_r;
  logic       hph_r;
  wire  [3:0] hacc_sum = {1'b0, hacc_r} + {1'b0, tfg_pkg::HALF_ADD};
  wire        half_ev  = (hacc_sum >= {1'b0, tfg_pkg::HALF_MOD});
  wire        bit_stb  = half_ev && !hph_r;
  wire        mid_stb  = half_ev && hph_r;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || frame_end) begin
      hacc_r <= '0;
      hph_r  <= 1'b0;
    end else begin
      hacc_r <= half_ev ? 3'(hacc_sum - {1'b0, tfg_pkg::HALF_MOD}) : hacc_sum[2:0];
      if (half_ev) hph_r <= ~hph_r;
    end
  end

  // sample FIFO; drained only in data slots
  wire ins_any = sync_w || fc_w || chk_w || dgap_w;
  wire fifo_bit;
  wire fifo_vld;
  wire data_take = bit_stb && !ins_any && !test_r;
  tfg_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (CLK_IN),
    .rst      (RST_IN),
    .wr_data  (SAMPLE_IN),
    .wr_valid (SAMPLE_VALID_IN),
    .wr_ready (SAMPLE_READY_OUT),
    .rd_data  (fifo_bit),
    .rd_valid (fifo_vld),
    .rd_ready (data_take)
  );

  // insertion field loaded at each window start, shifted MSB first
  logic [tfg_pkg::FLD_W-1:0] fld_r;
  wire  sync_ld = frame_go || (fcnt_r == CW'(TAIL_AT));
  wire  fc_ld   = (fcnt_r == CW'(tfg_pkg::SYNC_HEAD_CYC));
  wire  fld_ld  = sync_ld || fc_ld || chk_go;
  wire  [tfg_pkg::FLD_W-1:0] fld_new;
  wire  [tfg_pkg::FLD_W-1:0] fld_cur;
  assign fld_new = sync_ld ? tfg_pkg::SYNC_WORD :
                   fc_ld   ? {fnum_r, 14'h0000} :
                             {tfg_pkg::CHK_PAT, 16'h0000};
  // a load in a cell-start cycle hands its first bit to that cell
  assign fld_cur = fld_ld ? fld_new : fld_r;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      fld_r <= '0;
    end else if (bit_stb) begin
      fld_r <= {fld_cur[tfg_pkg::FLD_W-2:0], 1'b0};
    end else if (fld_ld) begin
      fld_r <= fld_cur;
    end
  end

  // test pattern index, one bit per cell, 30 cells = 7.5 us
  logic [4:0] tp_r;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      tp_r <= '0;
    end else if (bit_stb) begin
      tp_r <= (tp_r == 5'(tfg_pkg::TP_LEN - 1)) ? '0 : tp_r + 1'b1;
    end
  end
  wire tp_bit = tfg_pkg::TEST_PAT[5'(tfg_pkg::TP_LEN - 1) - tp_r];

  // bit selection; starved FIFO records a zero
  wire ins_fld = sync_w || fc_w || chk_w;
  wire nrz_nxt = ins_fld ? fld_cur[tfg_pkg::FLD_W-1] :
                 dgap_w  ? 1'b1 :
                 test_r  ? tp_bit :
                 (fifo_vld && fifo_bit);

  // recorded NRZ and diphase
  logic nrz_r, dp_r, bclk_r;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      nrz_r  <= 1'b0;
      dp_r   <= 1'b0;
      bclk_r <= 1'b0;
    end else if (bit_stb) begin
      nrz_r  <= nrz_nxt;
      dp_r   <= ~dp_r;
      bclk_r <= 1'b1;
    end else if (mid_stb) begin
      bclk_r <= 1'b0;
      if (nrz_r) dp_r <= ~dp_r;
    end
  end

  // registered timing outputs
  tfg_pkg::timing_out_t   tim_r;
  tfg_pkg::frame_strobes_t stb_r;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      tim_r <= '{tick60: 1'b0, tick1_n: 1'b1, fcnt_sync: 1'b0, ref60: 1'b0, aud_clk: 1'b0};
      stb_r <= '{default: 1'b0, write_data: 1'b1};
    end else begin
      tim_r.tick60    <= tick60_w;
      tim_r.tick1_n   <= ~tick1_w;
      tim_r.fcnt_sync <= fcs_w;
      tim_r.ref60     <= ref_w;
      tim_r.aud_clk   <= aud_r;
      stb_r.clk_interrogate <= ci_w;
      stb_r.write_gap       <= wgap_w;
      stb_r.sync_ins        <= sync_w;
      stb_r.fcnt_ins        <= fc_w;
      stb_r.chk_ins         <= chk_w;
      stb_r.write_data      <= ~dgap_w;
    end
  end

  assign TIMING_OUT     = tim_r;
  assign STROBES_OUT    = stb_r;
  assign NRZ_OUT        = nrz_r;
  assign BIT_CLK_OUT    = bclk_r;
  assign DIPHASE_OUT    = dp_r;
  assign TC_DIPHASE_OUT = tc_dp_r;
  assign TC_TAKE_OUT    = tc_cell;
endmodule : tfg_top
